// ---- hdl/rmlc_top.v ----
/*
 * radio modem link configuration and outgoing framer: register store,
 * serial driver control, master start-up sync sequencer, header
 * prepending, post-transmit hold-off and a two-entry output buffer.
 * assumes register writes arrive already decoded from the command
 * parser, all inputs synchronous to CLK, one byte per handshake.
 */
// Behaviour
// - no new data until hold-off expires
// - hold-off counted in 100 us units
// - destination 1..65535, 65535 means broadcast
// - hopping: repeater flag acts on master only
// - narrowband: repeater flag enables CSMA, network-wide
// - serial mode selects host port type
// - mode 2: driver on only while sending
// - mode 3: driver always on
// - sync mode master only, codes 0/1/2
// - mode 1: quick until ack, hold hops
// - mode 2: quick at online for timeout
// - timeout 100..65000 ms, used in mode 2
// - header enabled: prefix 00, FF, address
// - address high byte third, low fourth
`include "rmlc_defines.vh"

module rmlc_top #(
    parameter UNIT_CYCLES = `RMLC_DELAY_UNIT_US * `RMLC_CLK_MHZ, // cycles per 100 us
    parameter MS_CYCLES   = `RMLC_MS_US * `RMLC_CLK_MHZ          // cycles per ms
) (
    // clock and reset
    input  wire        CLK,
    input  wire        RST,
    // register port
    input  wire        REG_WE,
    input  wire        REG_RE,
    input  wire [7:0]  REG_NUM,
    input  wire [15:0] REG_WDATA,
    output reg  [15:0] REG_RDATA,
    // unit identity and role
    input  wire [15:0] UNIT_ID,
    input  wire        IS_MASTER,
    input  wire        IS_HOPPING,
    // link events
    input  wire        LINK_ONLINE,
    input  wire        SYNC_ACK,
    input  wire        HOP_TICK,
    // data from host
    input  wire        IN_VALID,
    input  wire [7:0]  IN_DATA,
    input  wire        IN_LAST,
    output reg         IN_READY,
    // data to radio
    output reg         TX_VALID,
    output reg  [7:0]  TX_DATA,
    output reg         TX_LAST,
    input  wire        TX_READY,
    // configuration outputs
    output reg  [15:0] DEST_ADDR,
    output reg         BROADCAST,
    output reg         REPEATER_MODE,
    output reg         CSMA_EN,
    output reg         LEGACY_COMPAT,
    output reg  [1:0]  SER_MODE,
    output reg         DRV_OE_N,
    output reg         FAST_HOP,
    output reg         HOLDOFF
);

    // ------------------------------------------------------------
    // state codes
    // ------------------------------------------------------------
    localparam [6:0] F_IDLE = 7'h01, F_H0 = 7'h02, F_H1 = 7'h04, F_H2 = 7'h08,
                     F_H3   = 7'h10, F_DATA = 7'h20, F_WAIT = 7'h40;
    localparam [3:0] S_NORM = 4'h1, S_QACK = 4'h2, S_QHOLD = 4'h4, S_QTMO = 4'h8;

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    reg [15:0] post_tx_delay_r;     // hold-off in 100 us units
    reg [7:0]  legacy_compat_r;     // legacy band flag
    reg [15:0] dest_addr_r;         // destination address
    reg [7:0]  repeater_r;          // repeater presence
    reg [7:0]  serial_mode_r;       // host port type
    reg [7:0]  sync_mode_r;         // master start-up sync mode
    reg [15:0] fast_timeout_r;      // quick sync time in ms
    reg [7:0]  hold_hops_r;         // hops kept fast after ack
    reg [7:0]  hdr_enable_r;        // header prepend enable

    // ------------------------------------------------------------
    // working state
    // ------------------------------------------------------------
    reg [6:0]  fstate_r;            // framer state
    reg [6:0]  fstate_nxt;
    reg [3:0]  sstate_r;            // sync sequencer state
    reg [16:0] hpre_r;              // hold-off prescaler
    reg [15:0] hcnt_r;              // hold-off units left
    reg [16:0] spre_r;              // ms prescaler
    reg [15:0] scnt_r;              // sync ms or hops left
    reg [7:0]  sp_data_r;           // spare buffer entry
    reg        sp_last_r;
    reg        sp_valid_r;
    reg        push;                // byte into the buffer
    reg [7:0]  push_data;
    reg        push_last;
    reg        sp_valid_nxt;
    wire       pop;                 // byte taken by radio
    wire       last_out;            // final byte of packet leaves

    assign pop      = TX_VALID & TX_READY;
    assign last_out = pop & TX_LAST;

    // ------------------------------------------------------------
    // register writes with range checks
    // ------------------------------------------------------------
    always @(posedge CLK) begin
        if (RST) begin
            post_tx_delay_r <= `RMLC_RST_POST_TX_DELAY;
            legacy_compat_r <= `RMLC_RST_BYTE;
            dest_addr_r     <= `RMLC_RST_DEST_ADDR;
            repeater_r      <= `RMLC_RST_BYTE;
            serial_mode_r   <= `RMLC_RST_BYTE;
            sync_mode_r     <= `RMLC_RST_BYTE;
            fast_timeout_r  <= `RMLC_RST_FAST_TIMEOUT;
            hold_hops_r     <= `RMLC_RST_HOLD_HOPS;
            hdr_enable_r    <= `RMLC_RST_BYTE;
        end else if (REG_WE) begin
            case (REG_NUM)
                `RMLC_REG_POST_TX_DELAY: post_tx_delay_r <= REG_WDATA;
                `RMLC_REG_LEGACY_COMPAT: legacy_compat_r <= REG_WDATA[7:0];
                `RMLC_REG_DEST_ADDR: begin
                    // zero is no legal destination, write dropped
                    if (REG_WDATA >= `RMLC_DEST_MIN)
                        dest_addr_r <= REG_WDATA;
                end
                `RMLC_REG_REPEATER: repeater_r <= REG_WDATA[7:0];
                `RMLC_REG_SERIAL_MODE: begin
                    if (REG_WDATA[7:0] <= `RMLC_SER_FULL485_ON)
                        serial_mode_r <= REG_WDATA[7:0];
                end
                `RMLC_REG_SYNC_MODE: begin
                    if (REG_WDATA[7:0] <= `RMLC_SYNC_QUICK_TMO)
                        sync_mode_r <= REG_WDATA[7:0];
                end
                `RMLC_REG_FAST_TIMEOUT: begin
                    if (REG_WDATA >= `RMLC_TMO_MIN && REG_WDATA <= `RMLC_TMO_MAX)
                        fast_timeout_r <= REG_WDATA;
                end
                `RMLC_REG_HOLD_HOPS: begin
                    if (REG_WDATA[7:0] >= `RMLC_HOPS_MIN)
                        hold_hops_r <= REG_WDATA[7:0];
                end
                `RMLC_REG_HDR_ENABLE: hdr_enable_r <= REG_WDATA[7:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // register read-back, unmapped numbers read zero
    // ------------------------------------------------------------
    always @(posedge CLK) begin
        if (RST) begin
            REG_RDATA <= 16'h0000;
        end else if (REG_RE) begin
            case (REG_NUM)
                `RMLC_REG_POST_TX_DELAY: REG_RDATA <= post_tx_delay_r;
                `RMLC_REG_LEGACY_COMPAT: REG_RDATA <= {8'h00, legacy_compat_r};
                `RMLC_REG_DEST_ADDR:     REG_RDATA <= dest_addr_r;
                `RMLC_REG_REPEATER:      REG_RDATA <= {8'h00, repeater_r};
                `RMLC_REG_SERIAL_MODE:   REG_RDATA <= {8'h00, serial_mode_r};
                `RMLC_REG_SYNC_MODE:     REG_RDATA <= {8'h00, sync_mode_r};
                `RMLC_REG_FAST_TIMEOUT:  REG_RDATA <= fast_timeout_r;
                `RMLC_REG_HOLD_HOPS:     REG_RDATA <= {8'h00, hold_hops_r};
                `RMLC_REG_HDR_ENABLE:    REG_RDATA <= {8'h00, hdr_enable_r};
                default:                 REG_RDATA <= 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // configuration outputs and serial driver control
    // ------------------------------------------------------------
    always @(posedge CLK) begin
        if (RST) begin
            DEST_ADDR     <= `RMLC_RST_DEST_ADDR;
            BROADCAST     <= 1'b0;
            REPEATER_MODE <= 1'b0;
            CSMA_EN       <= 1'b0;
            LEGACY_COMPAT <= 1'b0;
            SER_MODE      <= 2'b00;
            DRV_OE_N      <= 1'b1;
        end else begin
            DEST_ADDR     <= dest_addr_r;
            BROADCAST     <= (dest_addr_r == `RMLC_BROADCAST);
            // hopping units: only the master honours it
            REPEATER_MODE <= IS_HOPPING & IS_MASTER & (repeater_r != 8'h00);
            // narrowband units: same flag turns on CSMA
            CSMA_EN       <= ~IS_HOPPING & (repeater_r != 8'h00);
            LEGACY_COMPAT <= (legacy_compat_r != 8'h00);
            SER_MODE      <= serial_mode_r[1:0];
            case (serial_mode_r)
                `RMLC_SER_FULL485_ON: DRV_OE_N <= 1'b0;
                `RMLC_SER_FULL485_SW: DRV_OE_N <= ~TX_VALID;
                `RMLC_SER_HALF485:    DRV_OE_N <= ~TX_VALID;
                default:              DRV_OE_N <= 1'b1;        // rs-232, no 485 driver
            endcase
        end
    end

    // ------------------------------------------------------------
    // master start-up sync sequencer
    // ------------------------------------------------------------
    always @(posedge CLK) begin
        if (RST) begin
            sstate_r <= S_NORM;
            spre_r   <= 17'h00000;
            scnt_r   <= 16'h0000;
            FAST_HOP <= 1'b0;
        end else begin
            case (sstate_r)
                S_NORM: begin
                    // only a hopping master runs quick sync
                    if (LINK_ONLINE && IS_MASTER && IS_HOPPING) begin
                        if (sync_mode_r == `RMLC_SYNC_QUICK_ACK) begin
                            sstate_r <= S_QACK;
                        end else if (sync_mode_r == `RMLC_SYNC_QUICK_TMO) begin
                            sstate_r <= S_QTMO;
                            scnt_r   <= fast_timeout_r;
                            spre_r   <= 17'h00000;
                        end
                    end
                end
                S_QACK: begin
                    // fast until the slave acknowledges
                    if (SYNC_ACK) begin
                        sstate_r <= S_QHOLD;
                        scnt_r   <= {8'h00, hold_hops_r};
                    end
                end
                S_QHOLD: begin
                    // keep fast for the hold hop count
                    if (HOP_TICK) begin
                        if (scnt_r <= 16'h0001)
                            sstate_r <= S_NORM;
                        scnt_r <= scnt_r - 16'h0001;
                    end
                end
                S_QTMO: begin
                    // count whole ms down to zero
                    if (spre_r == MS_CYCLES[16:0] - 17'h00001) begin
                        spre_r <= 17'h00000;
                        if (scnt_r <= 16'h0001)
                            sstate_r <= S_NORM;
                        scnt_r <= scnt_r - 16'h0001;
                    end else begin
                        spre_r <= spre_r + 17'h00001;
                    end
                end
                default: sstate_r <= S_NORM;
            endcase
            FAST_HOP <= (sstate_r != S_NORM);
        end
    end

    // ------------------------------------------------------------
    // framer next state and byte source
    // ------------------------------------------------------------
    always @* begin
        fstate_nxt = fstate_r;
        push       = 1'b0;
        push_data  = IN_DATA;
        push_last  = 1'b0;
        case (fstate_r)
            F_IDLE: begin
                // a new packet only once hold-off is over
                if (IN_VALID && !HOLDOFF) begin
                    if (hdr_enable_r != 8'h00)
                        fstate_nxt = F_H0;
                    else
                        fstate_nxt = F_DATA;
                end
            end
            F_H0: begin
                push      = ~sp_valid_r;
                push_data = `RMLC_HDR_BYTE0;
                if (push)
                    fstate_nxt = F_H1;
            end
            F_H1: begin
                push      = ~sp_valid_r;
                push_data = `RMLC_HDR_BYTE1;
                if (push)
                    fstate_nxt = F_H2;
            end
            F_H2: begin
                push      = ~sp_valid_r;
                push_data = UNIT_ID[15:8];
                if (push)
                    fstate_nxt = F_H3;
            end
            F_H3: begin
                push      = ~sp_valid_r;
                push_data = UNIT_ID[7:0];
                if (push)
                    fstate_nxt = F_DATA;
            end
            F_DATA: begin
                // host bytes pass untouched
                push      = IN_VALID & IN_READY;
                push_last = IN_LAST;
                if (push && IN_LAST)
                    fstate_nxt = F_WAIT;
            end
            F_WAIT: begin
                // packet ends when its last byte leaves
                if (last_out)
                    fstate_nxt = F_IDLE;
            end
            default: fstate_nxt = F_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // two-entry buffer: head drives TX, spare absorbs a stall
    // ------------------------------------------------------------
    always @* begin
        sp_valid_nxt = sp_valid_r;
        if (pop && sp_valid_r)
            sp_valid_nxt = 1'b0;
        else if (push && TX_VALID && !pop)
            sp_valid_nxt = 1'b1;
    end

    always @(posedge CLK) begin
        if (RST) begin
            TX_VALID   <= 1'b0;
            TX_DATA    <= 8'h00;
            TX_LAST    <= 1'b0;
            sp_valid_r <= 1'b0;
            sp_data_r  <= 8'h00;
            sp_last_r  <= 1'b0;
        end else begin
            sp_valid_r <= sp_valid_nxt;
            if (pop && sp_valid_r) begin
                // spare moves up into the head
                TX_DATA <= sp_data_r;
                TX_LAST <= sp_last_r;
            end else if (push && (!TX_VALID || pop)) begin
                // head empty or emptying: load directly
                TX_VALID <= 1'b1;
                TX_DATA  <= push_data;
                TX_LAST  <= push_last;
            end else if (push) begin
                // head stalled: park in spare
                sp_data_r <= push_data;
                sp_last_r <= push_last;
            end else if (pop) begin
                TX_VALID <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // framer state and registered host ready
    // ------------------------------------------------------------
    always @(posedge CLK) begin
        if (RST) begin
            fstate_r <= F_IDLE;
            IN_READY <= 1'b0;
        end else begin
            fstate_r <= fstate_nxt;
            IN_READY <= (fstate_nxt == F_DATA) & ~sp_valid_nxt;
        end
    end

    // ------------------------------------------------------------
    // post-transmit hold-off in 100 us units
    // ------------------------------------------------------------
    always @(posedge CLK) begin
        if (RST) begin
            HOLDOFF <= 1'b0;
            hpre_r  <= 17'h00000;
            hcnt_r  <= 16'h0000;
        end else if (last_out) begin
            // zero delay means no hold-off at all
            HOLDOFF <= (post_tx_delay_r != 16'h0000);
            hcnt_r  <= post_tx_delay_r;
            hpre_r  <= 17'h00000;
        end else if (HOLDOFF) begin
            if (hpre_r == UNIT_CYCLES[16:0] - 17'h00001) begin
                hpre_r <= 17'h00000;
                if (hcnt_r <= 16'h0001)
                    HOLDOFF <= 1'b0;
                hcnt_r <= hcnt_r - 16'h0001;
            end else begin
                hpre_r <= hpre_r + 17'h00001;
            end
        end
    end

endmodule

// ---- hdl/rmlc_defines.vh ----
/*
 * constants for the radio modem link configuration block:
 * register numbers, field codes, reset values, limits and timing.
 * assumes a single 100 MHz clock; included by bare name.
 */
`ifndef RMLC_DEFINES_VH
`define RMLC_DEFINES_VH

// ----------------------------------------------------------------
// register numbers (index on the register port)
// ----------------------------------------------------------------
`define RMLC_REG_POST_TX_DELAY   8'h8A
`define RMLC_REG_LEGACY_COMPAT   8'h8B
`define RMLC_REG_DEST_ADDR       8'h8C
`define RMLC_REG_REPEATER        8'h8D
`define RMLC_REG_SERIAL_MODE     8'h8E
`define RMLC_REG_SYNC_MODE       8'h96
`define RMLC_REG_FAST_TIMEOUT    8'h97
`define RMLC_REG_HOLD_HOPS       8'h98
`define RMLC_REG_HDR_ENABLE      8'h99

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RMLC_RST_POST_TX_DELAY   16'h0000
`define RMLC_RST_DEST_ADDR       16'hFFFF
`define RMLC_RST_FAST_TIMEOUT    16'h00C8
`define RMLC_RST_HOLD_HOPS       8'h08
`define RMLC_RST_BYTE            8'h00

// ----------------------------------------------------------------
// field codes and limits
// ----------------------------------------------------------------
`define RMLC_BROADCAST           16'hFFFF
`define RMLC_DEST_MIN            16'h0001
`define RMLC_SER_RS232           8'h00
`define RMLC_SER_HALF485         8'h01
`define RMLC_SER_FULL485_SW      8'h02
`define RMLC_SER_FULL485_ON      8'h03
`define RMLC_SYNC_NORMAL         8'h00
`define RMLC_SYNC_QUICK_ACK      8'h01
`define RMLC_SYNC_QUICK_TMO      8'h02
`define RMLC_TMO_MIN             16'h0064
`define RMLC_TMO_MAX             16'hFDE8
`define RMLC_HOPS_MIN            8'h08
`define RMLC_HDR_BYTE0           8'h00
`define RMLC_HDR_BYTE1           8'hFF

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RMLC_CLK_MHZ             100
`define RMLC_DELAY_UNIT_US       100
`define RMLC_MS_US               1000

`endif

// ---- testbench/rmlc_properties.sv ----
/* port checker for rmlc_top.
   assumes bind from the bench top, one clock, sync high RST. */
module rmlc_properties (
    // clock and reset
    input logic        CLK,
    input logic        RST,
    // roles and events
    input logic        IS_MASTER,
    input logic        IS_HOPPING,
    input logic        LINK_ONLINE,
    // streams
    input logic        IN_READY,
    input logic        TX_VALID,
    input logic [7:0]  TX_DATA,
    input logic        TX_LAST,
    input logic        TX_READY,
    // config outputs
    input logic [15:0] DEST_ADDR,
    input logic        BROADCAST,
    input logic        REPEATER_MODE,
    input logic        CSMA_EN,
    input logic [1:0]  SER_MODE,
    input logic        DRV_OE_N,
    input logic        FAST_HOP,
    input logic        HOLDOFF
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    a_bcast_flag: assert property (1 |=> BROADCAST == (DEST_ADDR == 16'hFFFF))
        else $error("broadcast flag wrong");
    a_mode3_on: assert property (SER_MODE == 2'h3 && $past(SER_MODE) == 2'h3 |-> !DRV_OE_N)
        else $error("mode 3 driver off");
    a_mode0_off: assert property (SER_MODE == 2'h0 && $past(SER_MODE) == 2'h0 |-> DRV_OE_N)
        else $error("mode 0 driver on");
    a_mode2_switch: assert property (SER_MODE == 2'h2 && $past(SER_MODE) == 2'h2
        |-> DRV_OE_N == !$past(TX_VALID))
        else $error("mode 2 driver not following data");
    a_tx_stall: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST))
        else $error("stalled byte changed");
    a_hold_block: assert property (HOLDOFF |-> !IN_READY && !TX_VALID)
        else $error("data moved in hold-off");
    a_hold_start: assert property ($rose(HOLDOFF) |-> $past(TX_VALID && TX_READY && TX_LAST))
        else $error("hold-off without packet end");
    a_rep_master: assert property (REPEATER_MODE |-> $past(IS_MASTER && IS_HOPPING))
        else $error("repeater mode off master");
    a_csma_narrow: assert property (CSMA_EN |-> !$past(IS_HOPPING))
        else $error("csma on hopping unit");
    a_fast_cause: assert property ($rose(FAST_HOP) |-> $past(LINK_ONLINE && IS_MASTER && IS_HOPPING, 2))
        else $error("quick sync without online");
    // main scenarios seen
    c_hold: cover property (HOLDOFF ##1 !HOLDOFF);
    c_fast: cover property ($fell(FAST_HOP));
    c_stall: cover property (TX_VALID && !TX_READY);
endmodule

// ---- testbench/rmlc_radio_sink.sv ----
/* radio side model: takes bytes off the tx stream and logs them.
   assumes CLK and RST of the block; slow makes it stall 6 of 7 cycles. */
module rmlc_radio_sink (
    // clock and reset
    input  logic       CLK,
    input  logic       RST,
    // control
    input  logic       slow,
    // stream
    input  logic       TX_VALID,
    input  logic [7:0] TX_DATA,
    input  logic       TX_LAST,
    output logic       TX_READY
);
    // ----------------------------------------
    // byte log and ready pattern
    // ----------------------------------------
    logic [7:0] got[$];   // bytes taken
    logic       lastq[$]; // end marks taken
    int         cnt = 0;  // stall phase
    initial TX_READY = 1'b0;
    // log on handshake, change ready just after the edge
    always @(posedge CLK) begin
        if (TX_VALID && TX_READY) begin
            got.push_back(TX_DATA);
            lastq.push_back(TX_LAST);
        end
        cnt <= cnt + 1;
        TX_READY <= #1 !RST && (!slow || cnt % 7 == 6);
    end
endmodule

// ---- testbench/rmlc_tb_top.sv ----
/* self-checking bench for rmlc_top.
   assumes short counts: 10 cycles per delay unit and per ms. */
module rmlc_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk = 0, rst = 1, we = 0, re = 0, inv = 0, inl = 0, mst = 1, hop = 1, onl = 0, ack = 0, tick = 0, slow = 0;
    logic [7:0] num = 8'h00, ind = 8'h00;
    logic [15:0] wd = 16'h0000, uid = 16'hA55A;
    wire [15:0] rdat, dest;
    wire [7:0] txd;
    wire [1:0] ser;
    wire inr, txv, txl, txr, bc, rep, csma, leg, oe_n, fast, hold;
    int num_errors = 0, samples_checked = 0;
    always #5 clk = ~clk;
    rmlc_top #(.UNIT_CYCLES(10), .MS_CYCLES(10)) rmlc_top_i (.CLK(clk), .RST(rst), .REG_WE(we), .REG_RE(re),
        .REG_NUM(num), .REG_WDATA(wd), .REG_RDATA(rdat), .UNIT_ID(uid), .IS_MASTER(mst), .IS_HOPPING(hop),
        .LINK_ONLINE(onl), .SYNC_ACK(ack), .HOP_TICK(tick), .IN_VALID(inv), .IN_DATA(ind), .IN_LAST(inl),
        .IN_READY(inr), .TX_VALID(txv), .TX_DATA(txd), .TX_LAST(txl), .TX_READY(txr), .DEST_ADDR(dest),
        .BROADCAST(bc), .REPEATER_MODE(rep), .CSMA_EN(csma), .LEGACY_COMPAT(leg), .SER_MODE(ser),
        .DRV_OE_N(oe_n), .FAST_HOP(fast), .HOLDOFF(hold));
    rmlc_radio_sink rmlc_radio_sink_i (.CLK(clk), .RST(rst), .slow(slow), .TX_VALID(txv), .TX_DATA(txd),
        .TX_LAST(txl), .TX_READY(txr));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic stp(int n = 1);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic chk(logic [15:0] g, logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic to();
        num_errors++;
        $display("MISMATCH t=%0t wait ran out", $time);
        results();
    endtask
    task automatic wr(logic [7:0] n, logic [15:0] d);
        we = 1; num = n; wd = d;
        stp();
        we = 0;
        stp();
    endtask
    task automatic rd(logic [7:0] n, logic [15:0] e);
        re = 1; num = n;
        stp();
        re = 0;
        chk(rdat, e);
        stp();
    endtask
    task automatic lnk();
        onl = 1;
        stp();
        onl = 0;
    endtask
    // host bytes 10h.. ; waits for ready under a bound
    task automatic send(int n);
        int k;
        for (int i = 0; i < n; i++) begin
            inv = 1; ind = 8'h10 + i; inl = (i == n - 1); k = 0;
            while (!inr) begin
                stp();
                if (++k > 400) to();
            end
            stp();
        end
        inv = 0; inl = 0;
    endtask
    task automatic drain(int n);
        int k = 0;
        while (rmlc_radio_sink_i.got.size() < n) begin
            stp();
            if (++k > 400) to();
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        rd(8'h8C, 16'hFFFF); rd(8'h8A, 16'h0000); rd(8'h01, 16'h0000);
        rd(8'h97, 16'h00C8); rd(8'h98, 16'h0008); rd(8'h96, 16'h0000);
        wr(8'h8C, 16'h0000); rd(8'h8C, 16'hFFFF);
        wr(8'h8C, 16'h0001); rd(8'h8C, 16'h0001); chk(bc, 0);
        wr(8'h8C, 16'h0042); rd(8'h8C, 16'h0042); chk(dest, 16'h0042);
        wr(8'h8C, 16'hFFFF); chk(bc, 1);
        wr(8'h97, 16'h0063); wr(8'h97, 16'hFDE9); rd(8'h97, 16'h00C8);
        wr(8'h96, 16'h0003); rd(8'h96, 16'h0000); wr(8'h8E, 16'h0004); rd(8'h8E, 16'h0000);
        wr(8'h8B, 16'h0001); chk(leg, 1);
        $display("test regs done");
    endtask
    task automatic t_serial();
        for (int m = 0; m < 4; m++) begin
            wr(8'h8E, m); stp();
            chk(ser, m); chk(oe_n, m != 3);
        end
        wr(8'h8D, 16'h0001); stp(); chk(rep, 1);
        mst = 0; stp(2); chk(rep, 0);
        hop = 0; stp(2); chk(csma, 1);
        mst = 1; hop = 1; wr(8'h8D, 16'h0000);
        $display("test serial done");
    endtask
    task automatic t_pkt();
        logic [7:0] e[7] = '{8'h00, 8'hFF, 8'hA5, 8'h5A, 8'h10, 8'h11, 8'h12};
        int n = 0, k = 0;
        wr(8'h8E, 16'h0002); wr(8'h8A, 16'h0003); wr(8'h99, 16'h0001); slow = 1;
        send(3);
        while (!hold) begin
            stp();
            if (++k > 400) to();
        end
        while (hold && n < 100) begin
            n++; stp();
        end
        chk(n, 30);
        for (int i = 0; i < 7; i++) chk(rmlc_radio_sink_i.got[i], e[i]);
        for (int i = 0; i < 7; i++) chk(rmlc_radio_sink_i.lastq[i], i == 6);
        rmlc_radio_sink_i.got.delete();
        wr(8'h99, 16'h0000); wr(8'h8A, 16'h0000); slow = 0;
        send(2); drain(2); stp(3);
        chk(rmlc_radio_sink_i.got.size(), 2); chk(rmlc_radio_sink_i.got[0], 8'h10);
        chk(rmlc_radio_sink_i.got[1], 8'h11); chk(hold, 0);
        $display("test packet done");
    endtask
    task automatic t_sync();
        int n = 0;
        wr(8'h96, 16'h0002); wr(8'h97, 16'h0064); lnk(); stp();
        while (fast && n < 1100) begin
            n++; stp();
        end
        chk(n, 1000);
        wr(8'h96, 16'h0001); lnk(); stp(20); chk(fast, 1);
        ack = 1; stp(); ack = 0;
        for (int i = 0; i < 8; i++) begin
            stp(2); chk(fast, 1);
            tick = 1; stp(); tick = 0;
        end
        stp(3); chk(fast, 0);
        mst = 0; wr(8'h96, 16'h0002); lnk(); stp(4); chk(fast, 0);
        mst = 1; wr(8'h96, 16'h0000); lnk(); stp(4); chk(fast, 0);
        $display("test sync done");
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        stp(10);
        rst = 0;
        stp();
        t_regs();
        t_serial();
        t_pkt();
        t_sync();
        results();
    end
endmodule
bind rmlc_top rmlc_properties rmlc_properties_i (.CLK(CLK), .RST(RST), .IS_MASTER(IS_MASTER),
    .IS_HOPPING(IS_HOPPING), .LINK_ONLINE(LINK_ONLINE), .IN_READY(IN_READY), .TX_VALID(TX_VALID),
    .TX_DATA(TX_DATA), .TX_LAST(TX_LAST), .TX_READY(TX_READY), .DEST_ADDR(DEST_ADDR), .BROADCAST(BROADCAST),
    .REPEATER_MODE(REPEATER_MODE), .CSMA_EN(CSMA_EN), .SER_MODE(SER_MODE), .DRV_OE_N(DRV_OE_N),
    .FAST_HOP(FAST_HOP), .HOLDOFF(HOLDOFF));
